//--- logic/acbl_pkg.sv
// Package with opcodes, widths and constants for the accumulating compare and bit logic slice
package acbl_pkg;
  localparam int unsigned ACBL_DW = 32;
  localparam int unsigned ACBL_IMM_W = 9;
  localparam int unsigned ACBL_POS_W = 5;
  localparam int unsigned ACBL_BIT0 = 0;
  localparam logic [31:0] ACBL_RST_RESULT = 32'h0000_0000;

  typedef enum logic [3:0] {
    ACBL_OP_NONE,
    ACBL_OP_EQ,
    ACBL_OP_NE,
    ACBL_OP_GE,
    ACBL_OP_GEU,
    ACBL_OP_LT,
    ACBL_OP_LTU,
    ACBL_OP_BIT_AND,
    ACBL_OP_BIT_ANDN,
    ACBL_OP_ANDN
  } acbl_op_t;
endpackage : acbl_pkg

//--- logic/acbl_operand_sel.sv
// Second operand selection: register or extended nine bit immediate
module acbl_operand_sel (
  input wire logic [acbl_pkg::ACBL_DW-1:0] src_reg_second,
  input wire logic [acbl_pkg::ACBL_IMM_W-1:0] imm_nine_bit,
  input wire logic use_imm,
  input wire logic sign_ext,
  output logic [acbl_pkg::ACBL_DW-1:0] operand
);
  import acbl_pkg::*;
  logic [ACBL_DW-1:0] ext_imm;

  always_comb begin
    ext_imm = {{(ACBL_DW - ACBL_IMM_W){sign_ext & imm_nine_bit[ACBL_IMM_W-1]}}, imm_nine_bit};
    operand = use_imm ? ext_imm : src_reg_second;
  end
endmodule : acbl_operand_sel

//--- logic/acbl_compare.sv
// Equality and ordered compare of two 32-bit operands
module acbl_compare (
  input wire logic [acbl_pkg::ACBL_DW-1:0] a,
  input wire logic [acbl_pkg::ACBL_DW-1:0] b,
  output logic eq,
  output logic lt_s,
  output logic lt_u
);
  import acbl_pkg::*;

  always_comb begin
    eq = (a == b);
    lt_s = ($signed(a) < $signed(b));
    lt_u = (a < b);
  end
endmodule : acbl_compare

//--- logic/acbl_core.sv
// Accumulating compare and bit logic execution slice with registered writeback
// Behaviour
// - Equal: dest bit 0 ANDed with operand equality, upper bits kept.
// - Signed greater-or-equal ANDed into dest bit 0, immediate sign-extended.
// - Unsigned greater-or-equal ANDed into bit 0, immediate zero-extended.
// - Signed less-than ANDed into dest bit 0 only.
// - Unsigned less-than ANDed into dest bit 0, immediate zero-extended.
// - Not-equal ANDed into dest bit 0, immediate sign-extended, others kept.
// - Bit AND of two selected bits into bit 0, other bits cleared.
// - Bit AND with inverted second bit into bit 0, other bits cleared.
// - Full-width AND of first operand with complemented second operand.
// - AND-not immediate is zero-extended before inversion.
// - Compares accept register or nine-bit immediate second operand.
module acbl_core (
  input wire logic clk,
  input wire logic srst,
  input wire logic issue,
  input wire acbl_pkg::acbl_op_t op,
  input wire logic use_imm,
  input wire logic [acbl_pkg::ACBL_DW-1:0] src_reg_first,
  input wire logic [acbl_pkg::ACBL_DW-1:0] src_reg_second,
  input wire logic [acbl_pkg::ACBL_DW-1:0] dest_reg,
  input wire logic [acbl_pkg::ACBL_IMM_W-1:0] imm_nine_bit,
  input wire logic [acbl_pkg::ACBL_POS_W-1:0] first_bit_pos,
  input wire logic [acbl_pkg::ACBL_POS_W-1:0] second_bit_pos,
  output logic [acbl_pkg::ACBL_DW-1:0] result,
  output logic result_we,
  output logic psw_we
);
  import acbl_pkg::*;

  typedef struct packed {
    logic [ACBL_DW-1:0] result;
    logic we;
  } acbl_state_t;

  acbl_state_t state_q;
  acbl_state_t state_d;
  logic [ACBL_DW-1:0] opb;
  logic sign_ext;
  logic eq;
  logic lt_s;
  logic lt_u;
  logic cond;
  logic known;

  // Unsigned compares and AND-not use zero extension
  always_comb begin
    sign_ext = !(op == ACBL_OP_GEU || op == ACBL_OP_LTU || op == ACBL_OP_ANDN);
  end

  acbl_operand_sel u_sel (
    .src_reg_second(src_reg_second),
    .imm_nine_bit(imm_nine_bit),
    .use_imm(use_imm),
    .sign_ext(sign_ext),
    .operand(opb)
  );

  acbl_compare u_cmp (
    .a(src_reg_first),
    .b(opb),
    .eq(eq),
    .lt_s(lt_s),
    .lt_u(lt_u)
  );

  always_comb begin
    state_d = state_q;
    state_d.we = 1'b0;
    cond = 1'b0;
    known = 1'b1;
    unique case (op)
      ACBL_OP_EQ: cond = eq;
      ACBL_OP_NE: cond = !eq;
      ACBL_OP_GE: cond = !lt_s;
      ACBL_OP_GEU: cond = !lt_u;
      ACBL_OP_LT: cond = lt_s;
      ACBL_OP_LTU: cond = lt_u;
      default: known = 1'b0;
    endcase
    if (issue) begin
      unique case (op)
        ACBL_OP_EQ, ACBL_OP_NE, ACBL_OP_GE, ACBL_OP_GEU, ACBL_OP_LT, ACBL_OP_LTU: begin
          // Accumulate into bit 0, keep upper bits
          state_d.result = {dest_reg[ACBL_DW-1:1], dest_reg[ACBL_BIT0] & cond};
          state_d.we = known;
        end
        ACBL_OP_BIT_AND: begin
          state_d.result = {{(ACBL_DW-1){1'b0}},
            src_reg_first[first_bit_pos] & src_reg_second[second_bit_pos]};
          state_d.we = 1'b1;
        end
        ACBL_OP_BIT_ANDN: begin
          state_d.result = {{(ACBL_DW-1){1'b0}},
            src_reg_first[first_bit_pos] & !src_reg_second[second_bit_pos]};
          state_d.we = 1'b1;
        end
        ACBL_OP_ANDN: begin
          state_d.result = src_reg_first & ~opb;
          state_d.we = 1'b1;
        end
        default: state_d.we = 1'b0;
      endcase
    end
    if (srst) begin
      state_d.result = ACBL_RST_RESULT;
      state_d.we = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    state_q <= state_d;
  end

  always_comb begin
    result = state_q.result;
    result_we = state_q.we;
    psw_we = 1'b0;
  end

  sequence s_cmp_issue;
    issue && op inside {ACBL_OP_EQ, ACBL_OP_NE, ACBL_OP_GE, ACBL_OP_GEU, ACBL_OP_LT,
      ACBL_OP_LTU};
  endsequence

  chk_eq_accum: assert property (@(posedge clk) disable iff (srst)
    issue && op == ACBL_OP_EQ |=> result[0] == ($past(dest_reg[0])
      && $past(src_reg_first) == $past(opb)) && result_we)
    else $error("equal accumulate wrong");
  chk_upper_kept: assert property (@(posedge clk) disable iff (srst)
    s_cmp_issue |=> result[31:1] == $past(dest_reg[31:1]))
    else $error("upper bits changed");
  chk_ge_signed: assert property (@(posedge clk) disable iff (srst)
    issue && op == ACBL_OP_GE |=> result[0] == ($past(dest_reg[0])
      && ($signed($past(src_reg_first)) >= $signed($past(opb)))))
    else $error("signed ge wrong");
  chk_ge_unsigned: assert property (@(posedge clk) disable iff (srst)
    issue && op == ACBL_OP_GEU && use_imm |=> result[0] == ($past(dest_reg[0])
      && ($past(src_reg_first) >= {23'h00_0000, $past(imm_nine_bit)})))
    else $error("unsigned ge wrong");
  chk_lt_unsigned: assert property (@(posedge clk) disable iff (srst)
    issue && op == ACBL_OP_LTU |=> result[0] == ($past(dest_reg[0])
      && ($past(src_reg_first) < $past(opb))))
    else $error("unsigned lt wrong");
  chk_ne_imm: assert property (@(posedge clk) disable iff (srst)
    issue && op == ACBL_OP_NE && use_imm |=> result[0] == ($past(dest_reg[0])
      && $past(src_reg_first) != {{23{$past(imm_nine_bit[8])}}, $past(imm_nine_bit)}))
    else $error("not equal wrong");
  chk_bit_and: assert property (@(posedge clk) disable iff (srst)
    issue && op == ACBL_OP_BIT_AND |=> result[31:1] == 31'h0
      && result[0] == ($past(src_reg_first[first_bit_pos])
      && $past(src_reg_second[second_bit_pos])))
    else $error("bit and wrong");
  chk_bit_andn: assert property (@(posedge clk) disable iff (srst)
    issue && op == ACBL_OP_BIT_ANDN |=> result[31:1] == 31'h0
      && result[0] == ($past(src_reg_first[first_bit_pos])
      && !$past(src_reg_second[second_bit_pos])))
    else $error("bit and-not wrong");
  chk_andn_imm: assert property (@(posedge clk) disable iff (srst)
    issue && op == ACBL_OP_ANDN && use_imm |=> result ==
      ($past(src_reg_first) & ~{23'h00_0000, $past(imm_nine_bit)}))
    else $error("and-not immediate wrong");
  chk_andn_reg: assert property (@(posedge clk) disable iff (srst)
    issue && op == ACBL_OP_ANDN && !use_imm |=> result ==
      ($past(src_reg_first) & ~$past(src_reg_second)))
    else $error("and-not register wrong");
  chk_reg_form: assert property (@(posedge clk) disable iff (srst)
    s_cmp_issue ##0 (!use_imm && src_reg_first == src_reg_second && dest_reg[0]
      && op == ACBL_OP_EQ) |=> result[0])
    else $error("register form wrong");
  chk_no_status: assert property (@(posedge clk) disable iff (srst)
    !psw_we)
    else $error("status written");
  chk_idle_no_we: assert property (@(posedge clk) disable iff (srst)
    !issue |=> !result_we)
    else $error("spurious write");

  // Per compare operation issue sequences
  sequence s_eq_issue;
    issue && op == ACBL_OP_EQ;
  endsequence

  sequence s_ne_issue;
    issue && op == ACBL_OP_NE;
  endsequence

  sequence s_ge_issue;
    issue && op == ACBL_OP_GE;
  endsequence

  sequence s_geu_issue;
    issue && op == ACBL_OP_GEU;
  endsequence

  sequence s_lt_issue;
    issue && op == ACBL_OP_LT;
  endsequence

  sequence s_ltu_issue;
    issue && op == ACBL_OP_LTU;
  endsequence

  // Register and immediate forms of the compares; NE and GEU immediate forms are checked above
  chk_eq_imm: assert property (@(posedge clk) disable iff (srst)
    s_eq_issue ##0 use_imm |=> result[0] == ($past(dest_reg[0])
      && $past(src_reg_first) == {{23{$past(imm_nine_bit[8])}}, $past(imm_nine_bit)}))
    else $error("equal immediate wrong");

  chk_eq_reg: assert property (@(posedge clk) disable iff (srst)
    s_eq_issue ##0 !use_imm |=> result[0] == ($past(dest_reg[0])
      && $past(src_reg_first) == $past(src_reg_second)))
    else $error("equal register wrong");

  chk_ne_reg: assert property (@(posedge clk) disable iff (srst)
    s_ne_issue ##0 !use_imm |=> result[0] == ($past(dest_reg[0])
      && $past(src_reg_first) != $past(src_reg_second)))
    else $error("not equal register wrong");

  chk_ge_imm_s: assert property (@(posedge clk) disable iff (srst)
    s_ge_issue ##0 use_imm |=> result[0] == ($past(dest_reg[0])
      && ($signed($past(src_reg_first)) >=
      $signed({{23{$past(imm_nine_bit[8])}}, $past(imm_nine_bit)}))))
    else $error("signed ge immediate wrong");

  chk_ge_reg_s: assert property (@(posedge clk) disable iff (srst)
    s_ge_issue ##0 !use_imm |=> result[0] == ($past(dest_reg[0])
      && ($signed($past(src_reg_first)) >= $signed($past(src_reg_second)))))
    else $error("signed ge register wrong");

  chk_ge_reg_u: assert property (@(posedge clk) disable iff (srst)
    s_geu_issue ##0 !use_imm |=> result[0] == ($past(dest_reg[0])
      && ($past(src_reg_first) >= $past(src_reg_second))))
    else $error("unsigned ge register wrong");

  chk_lt_signed: assert property (@(posedge clk) disable iff (srst)
    s_lt_issue |=> result[0] == ($past(dest_reg[0])
      && ($signed($past(src_reg_first)) < $signed($past(opb)))))
    else $error("signed lt wrong");

  chk_lt_imm_s: assert property (@(posedge clk) disable iff (srst)
    s_lt_issue ##0 use_imm |=> result[0] == ($past(dest_reg[0])
      && ($signed($past(src_reg_first)) <
      $signed({{23{$past(imm_nine_bit[8])}}, $past(imm_nine_bit)}))))
    else $error("signed lt immediate wrong");

  chk_lt_imm_u: assert property (@(posedge clk) disable iff (srst)
    s_ltu_issue ##0 use_imm |=> result[0] == ($past(dest_reg[0])
      && ($past(src_reg_first) < {23'h00_0000, $past(imm_nine_bit)})))
    else $error("unsigned lt immediate wrong");

  chk_lt_reg_u: assert property (@(posedge clk) disable iff (srst)
    s_ltu_issue ##0 !use_imm |=> result[0] == ($past(dest_reg[0])
      && ($past(src_reg_first) < $past(src_reg_second))))
    else $error("unsigned lt register wrong");

  // Write enable and hold behaviour
  chk_cmp_we: assert property (@(posedge clk) disable iff (srst)
    s_cmp_issue |=> result_we)
    else $error("compare not written");

  chk_logic_we: assert property (@(posedge clk) disable iff (srst)
    issue && op inside {ACBL_OP_BIT_AND, ACBL_OP_BIT_ANDN, ACBL_OP_ANDN} |=> result_we)
    else $error("logic op not written");

  chk_none_no_we: assert property (@(posedge clk) disable iff (srst)
    issue && op == ACBL_OP_NONE |=> !result_we)
    else $error("none op wrote");

  chk_hold_idle: assert property (@(posedge clk) disable iff (srst)
    (!issue || op == ACBL_OP_NONE) |=> $stable(result))
    else $error("result changed while idle");

  // Second operand selection and full-width AND-not result
  chk_sel_reg: assert property (@(posedge clk) disable iff (srst)
    !use_imm |-> opb == src_reg_second)
    else $error("register operand wrong");

  chk_sel_sext: assert property (@(posedge clk) disable iff (srst)
    use_imm && op inside {ACBL_OP_EQ, ACBL_OP_NE, ACBL_OP_GE, ACBL_OP_LT}
      |-> opb == {{23{imm_nine_bit[8]}}, imm_nine_bit})
    else $error("sign extension wrong");

  chk_sel_zext: assert property (@(posedge clk) disable iff (srst)
    use_imm && op inside {ACBL_OP_GEU, ACBL_OP_LTU, ACBL_OP_ANDN}
      |-> opb == {23'h00_0000, imm_nine_bit})
    else $error("zero extension wrong");

  chk_andn_full: assert property (@(posedge clk) disable iff (srst)
    issue && op == ACBL_OP_ANDN |=> result == ($past(src_reg_first) & ~$past(opb)))
    else $error("and-not width wrong");
endmodule : acbl_core

//--- test/acbl_tb.sv
// Self-checking bench for the accumulating compare and bit logic slice
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import acbl_pkg::*;
  logic clk = 1'h0, srst = 1'h1, issue = 1'h0, use_imm = 1'h0;
  acbl_op_t op = ACBL_OP_NONE;
  logic [31:0] a = 32'h0000_0000, b = 32'h0000_0000, d = 32'h0000_0000;
  logic [31:0] result, last_e;
  logic [8:0] imm = 9'h000;
  logic [4:0] pos_a = 5'h00, pos_b = 5'h00;
  logic result_we, psw_we;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  acbl_core DUT (.clk(clk), .srst(srst), .issue(issue), .op(op), .use_imm(use_imm),
    .src_reg_first(a), .src_reg_second(b), .dest_reg(d), .imm_nine_bit(imm),
    .first_bit_pos(pos_a), .second_bit_pos(pos_b), .result(result), .result_we(result_we),
    .psw_we(psw_we));
  initial forever #5 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] exp_f(acbl_op_t o);
    logic [31:0] bb;
    logic c;
    bb = {{23{imm[8] && !(o inside {ACBL_OP_GEU, ACBL_OP_LTU, ACBL_OP_ANDN})}}, imm};
    bb = use_imm ? bb : b;
    case (o)
      ACBL_OP_EQ: c = a == bb;
      ACBL_OP_NE: c = a != bb;
      ACBL_OP_GE: c = $signed(a) >= $signed(bb);
      ACBL_OP_GEU: c = a >= bb;
      ACBL_OP_LT: c = $signed(a) < $signed(bb);
      ACBL_OP_LTU: c = a < bb;
      ACBL_OP_BIT_AND: return {31'h0000_0000, a[pos_a] & b[pos_b]};
      ACBL_OP_BIT_ANDN: return {31'h0000_0000, a[pos_a] & ~b[pos_b]};
      default: return a & ~bb;
    endcase
    return {d[31:1], d[0] & c};
  endfunction : exp_f
  task automatic go(input acbl_op_t o, input logic [31:0] av, bv, dv,
    input logic [8:0] iv, input logic ui);
    @(posedge clk);
    op <= o;
    issue <= 1'h1;
    a <= av;
    b <= bv;
    d <= dv;
    imm <= iv;
    use_imm <= ui;
    @(posedge clk);
    issue <= 1'h0;
    #1;
    last_e = exp_f(o);
    check(result_we, 1'h1);
    check(psw_we, 1'h0);
    check(result, last_e);
  endtask : go
  task automatic t_cmp();
    logic [31:0] xa[4] = '{32'h8000_0000, 32'hFFFF_FFFF, 32'h0000_01FF, 32'h0000_0005};
    logic [31:0] xb[4] = '{32'h0000_0001, 32'hFFFF_FFFF, 32'h0000_01FF, 32'h0000_0007};
    logic [8:0] xi[4] = '{9'h1FF, 9'h1FF, 9'h1FF, 9'h005};
    for (int o = 1; o < 7; o++) begin
      for (int k = 0; k < 8; k++) begin
        go(acbl_op_t'(o), xa[k/2], xb[k/2], 32'hDEAD_BEEE | 32'(k != 7), xi[k/2], k[0]);
      end
    end
    $display("t_cmp done");
  endtask : t_cmp
  task automatic t_bit();
    for (int q = 0; q < 32; q += 3) begin
      @(posedge clk);
      pos_a <= 5'(q);
      pos_b <= 5'(31 - q);
      go(ACBL_OP_BIT_AND, 32'h0F0F_F0F1, 32'h3C3C_C3C3, 32'hFFFF_FFFF, 9'h000, 1'h1);
      go(ACBL_OP_BIT_ANDN, 32'h0F0F_F0F1, 32'h3C3C_C3C3, 32'hFFFF_FFFF, 9'h000, 1'h1);
    end
    $display("t_bit done");
  endtask : t_bit
  task automatic t_andn();
    go(ACBL_OP_ANDN, 32'hFFFF_FFFF, 32'h1234_5678, 32'h0000_0000, 9'h1FF, 1'h0);
    go(ACBL_OP_ANDN, 32'hFFFF_FFFF, 32'h1234_5678, 32'h0000_0000, 9'h1FF, 1'h1);
    $display("t_andn done");
  endtask : t_andn
  task automatic t_idle();
    @(posedge clk);
    op <= ACBL_OP_NONE;
    issue <= 1'h1;
    a <= 32'h0000_0000;
    @(posedge clk);
    issue <= 1'h0;
    op <= ACBL_OP_EQ;
    repeat (2) @(posedge clk);
    #1;
    check(result_we, 1'h0);
    check(psw_we, 1'h0);
    check(result, last_e);
    $display("t_idle done");
  endtask : t_idle
  task automatic wrap_up();
    $display("Counts: checked=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'h0;
    #1;
    check(result, ACBL_RST_RESULT);
    check(result_we, 1'h0);
    t_cmp();
    t_bit();
    t_andn();
    t_idle();
    wrap_up();
  end
endmodule : tb
